// ===== src/phy_basic_control_register.sv
// phy basic control register, bits 15:10, with deferred speed/aneg commit
// Notes on behaviour
// - bit 15 resets phy, self-clears when done
// - bit 14 loops transmit data to receive
// - loopback holds the line link down
// - loopback rate from loopback speed field
// - forced speed code is bit6 msb, bit13 lsb
// - speed/aneg writes wait for reset, restart, wake
// - aneg enable is one after hardware reset
// - forced 1000 still negotiates, 1000BASE-T only
// - power down is bit 11 or copper bit
// - leaving power down resets and restarts aneg
// - gmii kept alive in power down if chosen
// - bit 11 loads pin at hardware reset only
// - pin edges set or clear bit 11
// - bit 10 reads zero, writes ignored
// - aneg restarts after every hardware/software reset
`timescale 1ns/1ps
module phy_basic_control_register
  import phy_ctrl_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_wr_en,
  input  wire logic        mgmt_rd_en,
  input  wire logic [15:0] mgmt_wdata,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rd_valid,
  input  wire logic        speed_msb_in,
  input  wire logic        duplex_in,
  input  wire logic        autoneg_restart_req,
  input  wire logic        copper_pd_in,
  input  wire logic        gmii_keep_in,
  input  wire logic [2:0]  loopback_speed_in,
  input  wire logic        ext_power_down_input,
  input  wire logic        ext_autoneg_restart_input,
  output logic             phy_sm_reset,
  output logic             autoneg_restart,
  output logic             loopback_en,
  output logic             link_force_down,
  output logic      [2:0]  rate_code,
  output logic      [1:0]  speed_code,
  output logic             autoneg_enable,
  output logic             adv_1000_only,
  output logic             adv_1000_full,
  output logic             power_down,
  output logic             gmii_shutdown
);
  import phy_ctrl_pkg::*;

  typedef struct packed {
    logic        loopback;
    logic        lsb_pend;
    logic        aneg_pend;
    logic        lsb_act;
    logic        aneg_act;
    logic        pd_bit;
    logic        pd_prev;
    logic        post_hw;
    logic [15:0] rdata;
    logic        rd_valid;
    logic        reset_out;
    logic        restart_out;
    logic        loop_out;
    logic        link_down_out;
    logic [2:0]  rate_out;
    logic [1:0]  speed_out;
    logic        aneg_out;
    logic        adv_only_out;
    logic        adv_full_out;
    logic        pd_out;
    logic        gmii_off_out;
  } ctrl_s;

  ctrl_s ctrl_reg;
  ctrl_s ctrl_next;

  logic [EDGE_W-1:0] pin_level;
  logic [EDGE_W-1:0] pin_rise;
  logic [EDGE_W-1:0] pin_fall;
  logic              seq_busy;
  logic              seq_done;
  logic              sw_start;
  logic              commit;
  logic              pd_now;
  logic              pd_exit;
  logic              ctrl_wr;
  logic              forced_1000;

  assign pin_level[EDGE_PD]   = ext_power_down_input;
  assign pin_level[EDGE_ANEG] = ext_autoneg_restart_input;

  edge_pair u_edges (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  soft_reset_seq u_seq (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (sw_start),
    .busy    (seq_busy),
    .done    (seq_done)
  );

  assign ctrl_wr = mgmt_wr_en & (mgmt_addr == CTRL_REG_ADDR);
  assign pd_now  = ctrl_reg.pd_bit | copper_pd_in;
  // only a fall of the combined level counts as leaving power down
  assign pd_exit = ~sys_rst & ctrl_reg.pd_prev & ~pd_now;
  assign sw_start = ~sys_rst & ((ctrl_wr & mgmt_wdata[BIT_SOFT_RESET]) | pd_exit);
  // any of the three events moves pending speed/aneg into use
  assign commit = sw_start | autoneg_restart_req | pin_rise[EDGE_ANEG];

  always_comb begin
    ctrl_next             = ctrl_reg;
    ctrl_next.rd_valid    = 1'b0;
    ctrl_next.restart_out = 1'b0;
    forced_1000           = 1'b0;
    if (sys_rst) begin
      ctrl_next.loopback  = LOOPBACK_RST;
      ctrl_next.lsb_pend  = SPEED_LSB_RST;
      ctrl_next.aneg_pend = ANEG_EN_RST;
      ctrl_next.lsb_act   = SPEED_LSB_RST;
      ctrl_next.aneg_act  = ANEG_EN_RST;
      // sampled under the synchronous reset, so a live level is allowed
      ctrl_next.pd_bit    = ext_power_down_input;
      ctrl_next.pd_prev   = ext_power_down_input | copper_pd_in;
      ctrl_next.post_hw   = 1'b1;
      ctrl_next.rdata     = '0;
    end else begin
      ctrl_next.post_hw = 1'b0;
      if (ctrl_wr) begin
        ctrl_next.loopback  = mgmt_wdata[BIT_LOOPBACK];
        ctrl_next.lsb_pend  = mgmt_wdata[BIT_SPEED_LSB];
        ctrl_next.aneg_pend = mgmt_wdata[BIT_ANEG_EN];
        ctrl_next.pd_bit    = mgmt_wdata[BIT_POWER_DOWN];
      end
      // pin edges win over a write in the same cycle
      if (pin_rise[EDGE_PD]) begin
        ctrl_next.pd_bit = 1'b1;
      end else if (pin_fall[EDGE_PD]) begin
        ctrl_next.pd_bit = 1'b0;
      end
      if (commit) begin
        ctrl_next.lsb_act  = ctrl_next.lsb_pend;
        ctrl_next.aneg_act = ctrl_next.aneg_pend;
      end
      // software reset clears loopback but keeps bit 11
      if (sw_start) begin
        ctrl_next.loopback = LOOPBACK_RST;
      end
      ctrl_next.pd_prev     = pd_now;
      ctrl_next.restart_out = ctrl_reg.post_hw | seq_done | commit;
      if (mgmt_rd_en) begin
        ctrl_next.rd_valid = 1'b1;
        ctrl_next.rdata    = '0;
        if (mgmt_addr == CTRL_REG_ADDR) begin
          ctrl_next.rdata[BIT_SOFT_RESET] = seq_busy;
          ctrl_next.rdata[BIT_LOOPBACK]   = ctrl_reg.loopback;
          ctrl_next.rdata[BIT_SPEED_LSB]  = ctrl_reg.lsb_pend;
          ctrl_next.rdata[BIT_ANEG_EN]    = ctrl_reg.aneg_pend;
          ctrl_next.rdata[BIT_POWER_DOWN] = ctrl_reg.pd_bit;
          ctrl_next.rdata[BIT_ISOLATE]    = ISOLATE_VAL;
        end
      end
    end
    ctrl_next.reset_out     = sw_start | seq_busy;
    ctrl_next.loop_out      = ctrl_next.loopback;
    ctrl_next.link_down_out = ctrl_next.loopback;
    ctrl_next.speed_out     = {speed_msb_in, ctrl_next.lsb_act};
    // loopback ignores the normal speed code
    ctrl_next.rate_out      = ctrl_next.loopback ? loopback_speed_in
                                                 : {1'b0, ctrl_next.speed_out};
    forced_1000             = ~ctrl_next.aneg_act & (ctrl_next.speed_out == SPEED_1000);
    ctrl_next.aneg_out      = ctrl_next.aneg_act | forced_1000;
    ctrl_next.adv_only_out  = forced_1000;
    ctrl_next.adv_full_out  = forced_1000 & duplex_in;
    ctrl_next.pd_out        = ctrl_next.pd_bit | copper_pd_in;
    ctrl_next.gmii_off_out  = ctrl_next.pd_out & ~gmii_keep_in;
  end

  always_ff @(posedge clk_sys) begin
    ctrl_reg <= ctrl_next;
  end

  assign mgmt_rdata      = ctrl_reg.rdata;
  assign mgmt_rd_valid   = ctrl_reg.rd_valid;
  assign phy_sm_reset    = ctrl_reg.reset_out;
  assign autoneg_restart = ctrl_reg.restart_out;
  assign loopback_en     = ctrl_reg.loop_out;
  assign link_force_down = ctrl_reg.link_down_out;
  assign rate_code       = ctrl_reg.rate_out;
  assign speed_code      = ctrl_reg.speed_out;
  assign autoneg_enable  = ctrl_reg.aneg_out;
  assign adv_1000_only   = ctrl_reg.adv_only_out;
  assign adv_1000_full   = ctrl_reg.adv_full_out;
  assign power_down      = ctrl_reg.pd_out;
  assign gmii_shutdown   = ctrl_reg.gmii_off_out;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_sw_reset_take: assert property (
    (ctrl_wr && mgmt_wdata[BIT_SOFT_RESET]) |=> phy_sm_reset ##[1:30] !phy_sm_reset)
    else $error("soft reset did not assert and self clear");

  a_loop_link_down: assert property (
    loopback_en |-> link_force_down)
    else $error("link not held down in loopback");

  a_loop_rate_src: assert property (
    loopback_en |-> rate_code == $past(loopback_speed_in))
    else $error("loopback rate not from loopback field");

  a_lsb_held_pend: assert property (
    $changed(speed_code[0]) |-> $past(commit))
    else $error("speed lsb changed without a commit event");

  a_hw_aneg_default: assert property (
    ($past(sys_rst) && !sys_rst) |-> autoneg_enable && !speed_code[0] ##1 autoneg_restart)
    else $error("hardware reset defaults or restart wrong");

  a_forced_adv_1000: assert property (
    adv_1000_only |-> autoneg_enable && speed_code == SPEED_1000
                      && adv_1000_full == $past(duplex_in))
    else $error("forced 1000 advertisement wrong");

  a_pd_or_copper: assert property (
    copper_pd_in |=> power_down)
    else $error("copper power down bit not honoured");

  // a register-bit exit drops power_down a cycle before the reset starts
  a_pd_exit_reset: assert property (
    $fell(pd_now) |=> phy_sm_reset && autoneg_restart)
    else $error("power down exit without reset and restart");

  a_gmii_shutdown: assert property (
    (power_down && !$past(gmii_keep_in)) |-> gmii_shutdown)
    else $error("gmii not shut down in power down");

  a_pin_rise_pd: assert property (
    $rose(ext_power_down_input) |=> power_down)
    else $error("pin rise did not set power down");

  a_pin_fall_pd: assert property (
    ($fell(ext_power_down_input) && !copper_pd_in) |=> !power_down)
    else $error("pin fall did not clear power down");

  a_isolate_zero: assert property (
    mgmt_rd_valid |-> !mgmt_rdata[BIT_ISOLATE])
    else $error("isolate bit read as one");

  a_loop_on_write: assert property (
    (ctrl_wr && mgmt_wdata[BIT_LOOPBACK] && !sw_start) |=> loopback_en)
    else $error("loopback write not applied");

  a_soft_keeps_pd: assert property (
    (sw_start && !ctrl_wr && !pin_rise[EDGE_PD] && !pin_fall[EDGE_PD])
      |=> ctrl_reg.pd_bit == $past(ctrl_reg.pd_bit))
    else $error("software reset changed bit 11");

  a_pend_readback: assert property (
    (mgmt_rd_en && mgmt_addr == CTRL_REG_ADDR) |=> mgmt_rd_valid
      && mgmt_rdata[BIT_SPEED_LSB] == $past(ctrl_reg.lsb_pend)
      && mgmt_rdata[BIT_ANEG_EN] == $past(ctrl_reg.aneg_pend))
    else $error("pending bits not read back");

  a_busy_readback: assert property (
    (mgmt_rd_en && mgmt_addr == CTRL_REG_ADDR)
      |=> mgmt_rdata[BIT_SOFT_RESET] == $past(seq_busy))
    else $error("reset busy bit read back wrong");

  a_reset_self_clear: assert property (
    (seq_done && !sw_start) |=> !phy_sm_reset)
    else $error("soft reset did not clear after done");

  a_link_up_no_loop: assert property (
    !loopback_en |-> !link_force_down)
    else $error("link held down outside loopback");

  a_normal_rate_src: assert property (
    !loopback_en |-> rate_code == {1'b0, speed_code})
    else $error("normal rate not from speed code");

  a_speed_msb_src: assert property (
    speed_code[1] == $past(speed_msb_in))
    else $error("speed msb not taken from input");

  a_aneg_held_pend: assert property (
    $changed(ctrl_reg.aneg_act) |-> $past(commit))
    else $error("aneg enable changed without a commit event");

  a_restart_on_done: assert property (
    seq_done |=> autoneg_restart)
    else $error("no restart after software reset");

  a_restart_pin_edge: assert property (
    pin_rise[EDGE_ANEG] |=> autoneg_restart)
    else $error("restart pin edge ignored");

  a_pd_both_clear: assert property (
    !power_down |-> !$past(copper_pd_in) && !ctrl_reg.pd_bit)
    else $error("left power down with a bit still set");

  c_loopback_on: cover property (ctrl_wr && mgmt_wdata[BIT_LOOPBACK] ##1 loopback_en);
  c_soft_reset_done: cover property ($fell(phy_sm_reset) && autoneg_restart);
  c_pd_exit: cover property ($fell(power_down));
  c_forced_1000: cover property (adv_1000_only && adv_1000_full);

endmodule // phy_basic_control_register

// ===== src/phy_ctrl_pkg.sv
// constants and types shared by the phy basic control register block
package phy_ctrl_pkg;

  // register location on the management port
  localparam logic [4:0] CTRL_REG_ADDR = 5'h00;

  // field positions inside the 16-bit control word
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_LOOPBACK   = 14;
  localparam int BIT_SPEED_LSB  = 13;
  localparam int BIT_ANEG_EN    = 12;
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_ISOLATE    = 10;

  // hardware reset values
  localparam logic SOFT_RESET_RST = 1'b0;
  localparam logic LOOPBACK_RST   = 1'b0;
  localparam logic SPEED_LSB_RST  = 1'b0;
  localparam logic ANEG_EN_RST    = 1'b1;
  localparam logic ISOLATE_VAL    = 1'b0;

  // forced speed codes, {msb, lsb}
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] SPEED_RSVD = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS       = 50;
  localparam int SOFT_RESET_TIME_NS  = 500;
  typedef logic [3:0] rst_cnt_t;
  localparam rst_cnt_t SOFT_RESET_CNT =
    rst_cnt_t'((SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // external strap inputs watched for edges
  localparam int EDGE_W    = 2;
  localparam int EDGE_PD   = 0;
  localparam int EDGE_ANEG = 1;

endpackage

// ===== src/edge_pair.sv
// rise and fall detector for the external control inputs
`timescale 1ns/1ps
module edge_pair
  import phy_ctrl_pkg::*;
(
  input  wire logic                            clk_sys,
  input  wire logic                            sys_rst,
  input  wire logic [phy_ctrl_pkg::EDGE_W-1:0] level,
  output logic      [phy_ctrl_pkg::EDGE_W-1:0] rise,
  output logic      [phy_ctrl_pkg::EDGE_W-1:0] fall
);

  typedef struct packed {
    logic [EDGE_W-1:0] prev;
  } edge_s;

  edge_s edge_reg;
  edge_s edge_next;

  // prev loads the live level in reset so release gives no false edge
  always_comb begin
    edge_next      = edge_reg;
    edge_next.prev = level;
  end

  always_ff @(posedge clk_sys) begin
    edge_reg <= edge_next;
  end

  for (genvar i = 0; i < EDGE_W; i++) begin : g_edge
    assign rise[i] = ~sys_rst & level[i] & ~edge_reg.prev[i];
    assign fall[i] = ~sys_rst & ~level[i] & edge_reg.prev[i];
  end

endmodule // edge_pair

// ===== src/soft_reset_seq.sv
// timed software reset sequencer for the phy state machines
`timescale 1ns/1ps
module soft_reset_seq
  import phy_ctrl_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  typedef struct packed {
    logic     busy;
    rst_cnt_t cnt;
    logic     done;
  } seq_s;

  seq_s seq_reg;
  seq_s seq_next;

  always_comb begin
    seq_next      = seq_reg;
    seq_next.done = 1'b0;
    if (sys_rst) begin
      seq_next = '0;
    end else if (start) begin
      // a new request restarts the full interval
      seq_next.busy = 1'b1;
      seq_next.cnt  = SOFT_RESET_CNT;
    end else if (seq_reg.busy) begin
      if (seq_reg.cnt == rst_cnt_t'(1)) begin
        seq_next.busy = 1'b0;
        seq_next.cnt  = '0;
        seq_next.done = 1'b1;
      end else begin
        seq_next.cnt = seq_reg.cnt - rst_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    seq_reg <= seq_next;
  end

  assign busy = seq_reg.busy;
  assign done = seq_reg.done;

endmodule // soft_reset_seq

// ===== tb/mac_mgmt_model.sv
// management-port master standing in for the controller on the far side
`timescale 1ns/1ps
module mac_mgmt_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_rd_valid,
  output logic      [4:0]  mgmt_addr,
  output logic             mgmt_wr_en,
  output logic             mgmt_rd_en,
  output logic      [15:0] mgmt_wdata
);
  initial begin
    mgmt_addr  = 5'h00;
    mgmt_wr_en = 1'b0;
    mgmt_rd_en = 1'b0;
    mgmt_wdata = 16'h0000;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    mgmt_addr  <= a;
    mgmt_wdata <= d;
    mgmt_wr_en <= 1'b1;
    @(posedge clk_sys);
    mgmt_wr_en <= 1'b0;
  endtask

  // bounded wait for the answer; ok low means it never came
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output bit ok);
    ok = 0;
    d  = 16'hxxxx;
    @(posedge clk_sys);
    mgmt_addr  <= a;
    mgmt_rd_en <= 1'b1;
    @(posedge clk_sys);
    mgmt_rd_en <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk_sys);
      if (mgmt_rd_valid === 1'b1) begin
        ok = 1;
        d  = mgmt_rdata;
      end
    end
  endtask

  // new speed bits are always followed by a software reset
  task automatic speed_change(input logic [15:0] d);
    wr(5'h00, d);
    wr(5'h00, d | 16'h8000);
  endtask
endmodule // mac_mgmt_model

// ===== tb/test_phy_basic_control_register.sv
// self-checking bench for the phy basic control register
`timescale 1ns/1ps
module test_phy_basic_control_register;
  import phy_ctrl_pkg::*;
  logic clk_sys = 0, sys_rst = 1, speed_msb_in = 0, duplex_in = 0, autoneg_restart_req = 0;
  logic copper_pd_in = 0, gmii_keep_in = 0, ext_power_down_input = 1, ext_autoneg_restart_input = 0;
  logic [2:0] loopback_speed_in = 3'h0, rate_code;
  logic [4:0] mgmt_addr;
  logic mgmt_wr_en, mgmt_rd_en, mgmt_rd_valid, phy_sm_reset, autoneg_restart, loopback_en;
  logic link_force_down, autoneg_enable, adv_1000_only, adv_1000_full, power_down, gmii_shutdown;
  logic [15:0] mgmt_wdata, mgmt_rdata, rv;
  logic [1:0] speed_code;
  int n_mismatch = 0, compares = 0;
  bit ok;

  always #25 clk_sys = ~clk_sys;

  phy_basic_control_register u_dut (.*);
  mac_mgmt_model u_mac (.*);

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // read back the control word; a missing answer ends the run
  task automatic rd_chk(string nm, logic [4:0] a, logic [15:0] exp);
    u_mac.rd(a, rv, ok);
    if (!ok) begin
      n_mismatch++;
      results();
    end
    chk(nm, rv, exp);
  endtask

  task automatic wait_rst(logic val);
    int i;
    for (i = 0; i < 40 && phy_sm_reset !== val; i++) @(negedge clk_sys);
    if (i == 40) begin
      n_mismatch++;
      results();
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  function automatic logic [15:0] ctrl(logic busy, lb, lsb, an, pd);
    return {busy, lb, lsb, an, pd, 11'h000};
  endfunction

  initial begin
    logic [4:0] ua;
    void'($urandom(32'h34d5));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    gmii_keep_in <= 1'($urandom);
    settle();
    rd_chk("reset word", 5'h00, ctrl(0, 0, 0, 1, 1));
    chk("pd at reset", power_down, 1'b1);
    chk("gmii off", gmii_shutdown, !gmii_keep_in);
    @(posedge clk_sys) ext_power_down_input <= 1'b0;
    wait_rst(1'b1);
    settle();
    chk("pd exit", power_down, 1'b0);
    wait_rst(1'b0);
    rd_chk("pin fall", 5'h00, ctrl(0, 0, 0, 1, 0));
    @(posedge clk_sys) speed_msb_in <= 1'($urandom);
    u_mac.wr(5'h00, 16'h2000);
    settle();
    chk("speed held", speed_code, {speed_msb_in, 1'b0});
    rd_chk("pending bits", 5'h00, ctrl(0, 0, 1, 0, 0));
    @(posedge clk_sys) autoneg_restart_req <= 1'b1;
    @(posedge clk_sys) autoneg_restart_req <= 1'b0;
    settle();
    chk("speed commit", speed_code, {speed_msb_in, 1'b1});
    @(posedge clk_sys) speed_msb_in <= 1'b1;
    duplex_in <= 1'($urandom);
    u_mac.speed_change(16'h0000);
    wait_rst(1'b1);
    wait_rst(1'b0);
    settle();
    chk("forced 1000", speed_code, SPEED_1000);
    chk("aneg kept", autoneg_enable, 1'b1);
    chk("adv only", adv_1000_only, 1'b1);
    chk("adv duplex", adv_1000_full, duplex_in);
    @(posedge clk_sys) loopback_speed_in <= 3'($urandom);
    u_mac.wr(5'h00, 16'h4000);
    settle();
    chk("loop on", loopback_en, 1'b1);
    chk("link down", link_force_down, 1'b1);
    chk("loop rate", rate_code, loopback_speed_in);
    @(posedge clk_sys) ext_autoneg_restart_input <= 1'b1;
    for (int i = 0; i < 8 && autoneg_restart !== 1'b1; i++) @(negedge clk_sys);
    chk("pin restart", autoneg_restart, 1'b1);
    @(posedge clk_sys) ext_autoneg_restart_input <= 1'b0;
    u_mac.wr(5'h00, 16'h8000);
    wait_rst(1'b1);
    rd_chk("reset busy", 5'h00, ctrl(1, 0, 0, 0, 0));
    wait_rst(1'b0);
    rd_chk("reset clears", 5'h00, ctrl(0, 0, 0, 0, 0));
    chk("loop off", loopback_en, 1'b0);
    chk("rate normal", rate_code, {1'b0, SPEED_1000});
    @(posedge clk_sys) copper_pd_in <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys) gmii_keep_in <= 1'(k);
      settle();
      chk("copper pd", power_down, 1'b1);
      chk("gmii keep", gmii_shutdown, !gmii_keep_in);
    end
    @(posedge clk_sys) ext_power_down_input <= 1'b1;
    settle();
    rd_chk("pin rise", 5'h00, ctrl(0, 0, 0, 0, 1));
    ua = 5'($urandom_range(31, 1));
    u_mac.wr(ua, 16'hffff);
    rd_chk("unmapped", ua, 16'h0000);
    u_mac.wr(5'h00, 16'h0c00);
    rd_chk("isolate", 5'h00, ctrl(0, 0, 0, 0, 1));
    // clear bit 11 by hand, then a hardware reset must reload it from the pin
    u_mac.wr(5'h00, 16'h0000);
    @(posedge clk_sys) sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    rd_chk("hw reset pd", 5'h00, ctrl(0, 0, 0, 1, 1));
    results();
  end
endmodule // test_phy_basic_control_register
